// >>> verilog/dacrb_consts.vh
`ifndef DACRB_CONSTS_VH
`define DACRB_CONSTS_VH

// =====================================================================
// register offsets
`define DACRB_ADDR_C_LOW 8'h14
`define DACRB_ADDR_C_HIGH 8'h15
`define DACRB_ADDR_D_LOW 8'h16
`define DACRB_ADDR_D_HIGH 8'h17
`define DACRB_ADDR_CTRL1 8'h18
`define DACRB_ADDR_IRQ_STATUS 8'h1E
`define DACRB_ADDR_IRQ_MASK 8'h1F

// =====================================================================
// reset values
`define DACRB_RESET_DATA 8'h00
`define DACRB_RESET_CTRL1 8'h00
`define DACRB_RESET_IRQ 8'h00

// =====================================================================
// control register 1 field positions
`define DACRB_BIT_RUN 0
`define DACRB_BIT_PIN78_LO 1
`define DACRB_BIT_PIN78_HI 2
`define DACRB_BIT_PIN9 3
`define DACRB_BIT_RSVD 4
`define DACRB_BIT_IRQ_DIS 5
`define DACRB_BIT_IRQ_POL 6
`define DACRB_BIT_STANDBY 7

// pin 7/8 function codes
`define DACRB_PIN78_AIN 2'h0
`define DACRB_PIN78_DIODE 2'h2

// =====================================================================
// event status bit positions
`define DACRB_EV_C_WRITE 0
`define DACRB_EV_D_WRITE 1
`define DACRB_EV_C_LOAD 2
`define DACRB_EV_D_LOAD 3
`define DACRB_EV_STANDBY 4
`define DACRB_EV_RSVD_WR 5
`define DACRB_EV_PIN78_BAD 6

`endif

// >>> verilog/dacrb_regs.v
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
`include "dacrb_consts.vh"

module dacrb_regs #(
  parameter DAC_BITS = 12
) (
  input wire clock,
  input wire rst,
  input wire [7:0] regAddr,
  input wire [7:0] regWriteData,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regReadData,
  input wire dacLoadInput_n,
  input wire updateSourceSelect,
  input wire configLoadStrobe,
  input wire deviceEvent,
  output reg [DAC_BITS-1:0] channelCCode,
  output reg [DAC_BITS-1:0] channelDCode,
  output wire monitorRun,
  output wire [1:0] pin78FunctionSelect,
  output wire pin9FunctionSelect,
  output wire pin78Undefined,
  output wire standby,
  output wire dacPowerDown,
  output wire irqPin,
  output wire irqPinEnable_n,
  output wire irqLevel
);

  localparam LOW_BITS = DAC_BITS - 8;
  localparam [7:0] LOW_MASK = (8'hFF << (8 - LOW_BITS));

  // =====================================================================
  // register storage
  reg [7:0] cLow;
  reg [7:0] cHigh;
  reg [7:0] dLow;
  reg [7:0] dHigh;
  reg [7:0] controlSetupOne;
  reg [7:0] irqStatus;
  reg [7:0] irqMask;
  reg loadPinLast;
  reg [7:0] next_readData;
  reg [DAC_BITS-1:0] next_channelCCode;
  reg [DAC_BITS-1:0] next_channelDCode;

  function hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  // top LOW_BITS positions of a low-bits register
  function [LOW_BITS-1:0] lowField;
    input [7:0] value;
    begin
      lowField = value[7:8-LOW_BITS];
    end
  endfunction

  wire wrCLow = regWrite && hit(regAddr, `DACRB_ADDR_C_LOW);
  wire wrCHigh = regWrite && hit(regAddr, `DACRB_ADDR_C_HIGH);
  wire wrDLow = regWrite && hit(regAddr, `DACRB_ADDR_D_LOW);
  wire wrDHigh = regWrite && hit(regAddr, `DACRB_ADDR_D_HIGH);
  wire wrCtrl = regWrite && hit(regAddr, `DACRB_ADDR_CTRL1);
  wire wrStatus = regWrite && hit(regAddr, `DACRB_ADDR_IRQ_STATUS);
  wire wrMask = regWrite && hit(regAddr, `DACRB_ADDR_IRQ_MASK);

  // =====================================================================
  // channel C data registers
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      cLow <= `DACRB_RESET_DATA;
    end else if (wrCLow) begin
      cLow <= regWriteData & LOW_MASK;
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      cHigh <= `DACRB_RESET_DATA;
    end else if (wrCHigh) begin
      cHigh <= regWriteData;
    end
  end

  // =====================================================================
  // channel D data registers
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      dLow <= `DACRB_RESET_DATA;
    end else if (wrDLow) begin
      dLow <= regWriteData & LOW_MASK;
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      dHigh <= `DACRB_RESET_DATA;
    end else if (wrDHigh) begin
      dHigh <= regWriteData;
    end
  end

  // =====================================================================
  // control register and interrupt mask
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      controlSetupOne <= `DACRB_RESET_CTRL1;
    end else if (wrCtrl) begin
      controlSetupOne <= regWriteData;
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      irqMask <= `DACRB_RESET_IRQ;
    end else if (wrMask) begin
      irqMask <= regWriteData;
    end
  end

  // =====================================================================
  // control decode
  assign monitorRun = controlSetupOne[`DACRB_BIT_RUN];
  assign pin78FunctionSelect =
    controlSetupOne[`DACRB_BIT_PIN78_HI:`DACRB_BIT_PIN78_LO];
  assign pin78Undefined = (pin78FunctionSelect != `DACRB_PIN78_AIN) &&
    (pin78FunctionSelect != `DACRB_PIN78_DIODE);
  assign pin9FunctionSelect = controlSetupOne[`DACRB_BIT_PIN9];
  assign standby = controlSetupOne[`DACRB_BIT_STANDBY];
  assign dacPowerDown = standby;

  // update source: config registers only while pin 9 is the load input
  wire useConfigSource = updateSourceSelect && !pin9FunctionSelect;
  wire loadPinActive = !pin9FunctionSelect && !dacLoadInput_n;
  wire loadPinFall = loadPinActive && !loadPinLast;
  wire doLoad = useConfigSource ? configLoadStrobe : loadPinFall;

  // =====================================================================
  // load pin edge detect
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      loadPinLast <= 1'b0;
    end else begin
      loadPinLast <= loadPinActive;
    end
  end

  // =====================================================================
  // channel C output code, transferred on a load event
  always @* begin
    next_channelCCode = channelCCode;
    if (standby) begin
      next_channelCCode = {DAC_BITS{1'b0}};
    end else if (doLoad) begin
      next_channelCCode = {cHigh, lowField(cLow)};
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      channelCCode <= {DAC_BITS{1'b0}};
    end else begin
      channelCCode <= next_channelCCode;
    end
  end

  // =====================================================================
  // channel D output code, transferred on a load event
  always @* begin
    next_channelDCode = channelDCode;
    if (standby) begin
      next_channelDCode = {DAC_BITS{1'b0}};
    end else if (doLoad) begin
      next_channelDCode = {dHigh, lowField(dLow)};
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      channelDCode <= {DAC_BITS{1'b0}};
    end else begin
      channelDCode <= next_channelDCode;
    end
  end

  // =====================================================================
  // events and interrupt
  wire [7:0] eventVec;
  assign eventVec[`DACRB_EV_C_WRITE] = wrCLow || wrCHigh;
  assign eventVec[`DACRB_EV_D_WRITE] = wrDLow || wrDHigh;
  assign eventVec[`DACRB_EV_C_LOAD] = doLoad && !standby;
  assign eventVec[`DACRB_EV_D_LOAD] = deviceEvent;
  assign eventVec[`DACRB_EV_STANDBY] = wrCtrl && regWriteData[`DACRB_BIT_STANDBY];
  assign eventVec[`DACRB_EV_RSVD_WR] = wrCtrl && regWriteData[`DACRB_BIT_RSVD];
  assign eventVec[`DACRB_EV_PIN78_BAD] = pin78Undefined;
  assign eventVec[7] = 1'b0;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : gStatus
      always @(posedge clock or posedge rst) begin
        if (rst) begin
          irqStatus[gi] <= 1'b0;
        end else if (eventVec[gi]) begin
          irqStatus[gi] <= 1'b1;
        end else if (wrStatus && regWriteData[gi]) begin
          irqStatus[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // =====================================================================
  // interrupt output
  // a set mask bit blocks its status bit
  assign irqLevel = |(irqStatus & ~irqMask);
  wire irqOn = irqLevel && !controlSetupOne[`DACRB_BIT_IRQ_DIS];
  assign irqPin = controlSetupOne[`DACRB_BIT_IRQ_POL] ? irqOn : !irqOn;
  assign irqPinEnable_n = controlSetupOne[`DACRB_BIT_IRQ_DIS];

  // =====================================================================
  // read port
  always @* begin
    next_readData = 8'h00;
    if (regRead) begin
      case (regAddr)
        `DACRB_ADDR_C_LOW: next_readData = cLow;
        `DACRB_ADDR_C_HIGH: next_readData = cHigh;
        `DACRB_ADDR_D_LOW: next_readData = dLow;
        `DACRB_ADDR_D_HIGH: next_readData = dHigh;
        `DACRB_ADDR_CTRL1: next_readData = controlSetupOne;
        `DACRB_ADDR_IRQ_STATUS: next_readData = irqStatus;
        `DACRB_ADDR_IRQ_MASK: next_readData = irqMask;
        default: next_readData = 8'h00;
      endcase
    end
  end

  // read data stand in the cycle after each cycle of the read strobe, zero otherwise
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      regReadData <= 8'h00;
    end else begin
      regReadData <= next_readData;
    end
  end

endmodule

// >>> test/dacrb_regs_assertions.sv
`timescale 1ns/100ps
// ========================================
// register bank port checks
module dacrb_regs_assertions #(parameter DAC_BITS = 12) (
  input wire clock,
  input wire rst,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regAddr,
  input wire [7:0] regWriteData,
  input wire [7:0] regReadData,
  input wire [DAC_BITS-1:0] channelCCode,
  input wire monitorRun,
  input wire standby,
  input wire [1:0] pin78FunctionSelect,
  input wire pin9FunctionSelect,
  input wire pin78Undefined,
  input wire dacPowerDown,
  input wire irqPinEnable_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire ctlWr = regWrite && regAddr == 8'h18;
  a_run_bit: assert property (ctlWr |=> monitorRun == $past(regWriteData[0]))
    else $error("run bit wrong");
  a_pin_select: assert property (
    ctlWr |=> pin78FunctionSelect == $past(regWriteData[2:1]) &&
      pin9FunctionSelect == $past(regWriteData[3]))
    else $error("pin select wrong");
  a_undef_code: assert property (pin78Undefined == pin78FunctionSelect[0])
    else $error("undefined flag wrong");
  a_irq_enable: assert property (ctlWr |=> irqPinEnable_n == $past(regWriteData[5]))
    else $error("irq enable wrong");
  a_standby_bit: assert property (
    ctlWr |=> standby == $past(regWriteData[7]) && dacPowerDown == standby)
    else $error("standby wrong");
  a_standby_zero: assert property (standby ##1 standby |-> channelCCode == 0)
    else $error("code not zero in standby");
  a_load_block: assert property (
    pin9FunctionSelect && !standby ##1 !standby |-> channelCCode == $past(channelCCode))
    else $error("load not blocked");
  a_read_idle: assert property (!$past(regRead) |-> regReadData == 8'h00)
    else $error("read data outside slot");
  c_standby: cover property (ctlWr && regWriteData[7]);
  c_pin9: cover property (pin9FunctionSelect ##1 !pin9FunctionSelect);
  c_read: cover property (regRead ##1 regReadData != 8'h00);
  c_undef: cover property (pin78Undefined);
endmodule
bind dacrb_regs dacrb_regs_assertions #(.DAC_BITS(DAC_BITS)) i_chk (.clock(clock), .rst(rst),
  .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWriteData(regWriteData),
  .regReadData(regReadData), .channelCCode(channelCCode), .monitorRun(monitorRun),
  .standby(standby), .pin78FunctionSelect(pin78FunctionSelect), .dacPowerDown(dacPowerDown),
  .pin9FunctionSelect(pin9FunctionSelect), .pin78Undefined(pin78Undefined),
  .irqPinEnable_n(irqPinEnable_n));

// >>> test/dacrb_host_model.sv
`timescale 1ns/100ps
// ========================================
// host side of the register port
module dacrb_host_model (
  input wire clock,
  input wire [7:0] regReadData,
  output reg [7:0] regAddr = 8'h00,
  output reg [7:0] regWriteData = 8'h00,
  output reg regWrite = 1'b0,
  output reg regRead = 1'b0
);
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clock);
      regAddr <= a;
      regWriteData <= (a == 8'h18) ? d & 8'hEF : d;
      regWrite <= 1'b1;
      @(posedge clock);
      regWrite <= 1'b0;
      regWriteData <= ~d;
    end
  endtask
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(posedge clock);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      // data stand in the cycle after the strobe; take them at its closing edge
      @(posedge clock);
      d = regReadData;
    end
  endtask
endmodule

// >>> test/tb_top.sv
`timescale 1ns/100ps
// ========================================
// bench
module tb_top;
  reg clock = 0, rst = 1, loadN = 1, upd = 0, cfgLoad = 0, devEv = 0;
  wire [7:0] regAddr, regWriteData, regReadData;
  wire regWrite, regRead, irqPin, irqPinEnable_n, irqLevel, standby, dacPowerDown;
  wire [11:0] cCode, dCode;
  integer fails = 0, samplesChecked = 0, cycles = 0, i;
  reg [31:0] seed = 32'h00011A46;
  reg [7:0] rdv, lo, hi, a;
  reg [11:0] lastC;
  always #25 clock = ~clock;
  dacrb_host_model i_host (.clock(clock), .regReadData(regReadData), .regAddr(regAddr),
    .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead));
  dacrb_regs i_dut (.clock(clock), .rst(rst), .regAddr(regAddr), .regWriteData(regWriteData),
    .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData), .dacLoadInput_n(loadN),
    .updateSourceSelect(upd), .configLoadStrobe(cfgLoad), .deviceEvent(devEv),
    .channelCCode(cCode), .channelDCode(dCode), .monitorRun(), .pin78FunctionSelect(),
    .pin9FunctionSelect(), .pin78Undefined(), .standby(standby), .dacPowerDown(dacPowerDown),
    .irqPin(irqPin), .irqPinEnable_n(irqPinEnable_n), .irqLevel(irqLevel));
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [11:0] code(input [7:0] h, input [7:0] l);
    code = {h, l[7:4]};
  endfunction
  task chk(input string name, input [15:0] seen, input [15:0] exp);
    begin
      samplesChecked = samplesChecked + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("BAD %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task rdchk(input [7:0] ad, input [7:0] e);
    begin
      i_host.rd(ad, rdv);
      chk("readback", rdv, e);
    end
  endtask
  task pulse(input integer which);
    begin
      @(posedge clock);
      if (which == 0) begin
        loadN <= 0;
      end else if (which == 1) begin
        cfgLoad <= 1;
      end else begin
        devEv <= 1;
      end
      @(posedge clock);
      {loadN, cfgLoad, devEv} <= 3'b100;
      repeat (2) @(posedge clock);
    end
  endtask
  // let a write and its follow-on register stage land before looking
  task settle;
    begin
      @(posedge clock);
      @(negedge clock);
    end
  endtask
  task end_of_test;
    begin
      if (fails == 0 && samplesChecked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      end_of_test;
    end
  end
  initial begin
    repeat (3) @(posedge clock);
    rst <= 0;
    for (i = 8'h14; i < 8'h19; i = i + 1) rdchk(i[7:0], 8'h00);
    chk("irqPin", irqPin, 1);
    for (i = 0; i < 20; i = i + 1) begin
      seed = lfsr(seed);
      {hi, lo} = seed[15:0];
      a = i[0] ? 8'h16 : 8'h14;
      i_host.wr(a, lo);
      i_host.wr(a + 8'h01, hi);
      rdchk(a, lo & 8'hF0);
      rdchk(a + 8'h01, hi);
      pulse(0);
      chk("code", i[0] ? dCode : cCode, code(hi, lo));
      if (!i[0]) lastC = code(hi, lo);
    end
    i_host.wr(8'h30, 8'h5A);
    rdchk(8'h30, 8'h00);
    i_host.wr(8'h18, 8'h1D);
    rdchk(8'h18, 8'h0D);
    i_host.wr(8'h15, 8'h00);
    upd <= 1;
    pulse(0);
    pulse(1);
    chk("blocked", cCode, lastC);
    i_host.wr(8'h18, 8'h04);
    pulse(1);
    chk("cfg load", cCode, code(8'h00, lastC[3:0] << 4));
    i_host.wr(8'h18, 8'h80);
    settle;
    chk("powerdown", dacPowerDown, 1);
    chk("standby code", cCode, 0);
    chk("standby code d", dCode, 0);
    chk("irqLevel", irqLevel, 1);
    i_host.wr(8'h18, 8'h00);
    settle;
    chk("irq low", irqPin, 0);
    chk("irq on", irqPinEnable_n, 0);
    i_host.wr(8'h18, 8'h40);
    settle;
    chk("irq high", irqPin, 1);
    i_host.wr(8'h18, 8'h20);
    settle;
    chk("irq off", irqPinEnable_n, 1);
    chk("irq idle", irqPin, 1);
    i_host.wr(8'h1F, 8'hFF);
    settle;
    chk("masked", irqLevel, 0);
    i_host.wr(8'h1F, 8'h00);
    i_host.wr(8'h1E, 8'hFF);
    settle;
    chk("cleared", irqLevel, 0);
    pulse(2);
    chk("event", irqLevel, 1);
    rdchk(8'h1E, 8'h08);
    i_host.wr(8'h18, 8'h02);
    settle;
    rdchk(8'h1E, 8'h48);
    end_of_test;
  end
endmodule
